/* File: core/rfpkd_params.svh */
`ifndef RFPKD_PARAMS_SVH
`define RFPKD_PARAMS_SVH
`define RFPKD_CLK_NS 10
`define RFPKD_SIL_UNIT_NS 200000
`define RFPKD_PWM_STEP_NS 208000
`define RFPKD_HOLD_UNIT_NS 100000000
`define RFPKD_PWM_STEPS 6'h28
`define RFPKD_PWM_MAX_DUTY 6'h26
`define RFPKD_PWM_BASE 6'h0D
`define RFPKD_MARGIN_CAP 8'h28
`define RFPKD_HOLD_FOREVER 8'hFF
`define RFPKD_CODE_FAULT 8'h0F
`define RFPKD_CODE_GOOD 8'h10
`define RFPKD_CODE_FACTORY 8'h0E
`define RFPKD_CODE_FWVER 8'h14
`define RFPKD_CODE_IN2 8'h16
`define RFPKD_CODE_DROP 8'h1B
`define RFPKD_CODE_LEVEL 8'h1C
`define RFPKD_CODE_THRESH 8'h20
`define RFPKD_CODE_SILENCE 8'h21
`define RFPKD_CODE_HOLD 8'h22
`define RFPKD_CODE_SER_HI 8'h25
`define RFPKD_CODE_SER_LO 8'h26
`define RFPKD_CODE_MAXPKT 8'h29
`define RFPKD_CODE_BUFSZ 8'h2C
`define RFPKD_MAXPKT_MIN 16'h0002
`define RFPKD_MAXPKT_MAX 16'h0100
`define RFPKD_MAXPKT_RST 16'h0040
`define RFPKD_THRESH_RST 16'h0001
`define RFPKD_IN2_MAX 8'h02
`define RFPKD_IN2_BINCMD 8'h01
`define RFPKD_IN2_RTS 8'h02
`define RFPKD_TALLY_MAX 16'hFFFF
`define RFPKD_STRAP_SETTLE 2'h3
`endif

/* File: core/rfpkd_pkg.sv */
package rfpkd_pkg;
	// one host command: code selects the parameter, write flags a load of data
	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} rfpkd_cmd_t;

	// one received rf packet report
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] margin_db;
	} rfpkd_rxpkt_t;

	typedef enum logic [1:0] {
		RFPKD_GATHER,
		RFPKD_STREAM
	} rfpkd_pk_state_t;

	typedef enum logic [1:0] {
		RFPKD_PIN_SETTLE,
		RFPKD_PIN_LOW,
		RFPKD_PIN_PWM
	} rfpkd_pin_state_t;
endpackage : rfpkd_pkg

/* File: core/rfpkd_regs.sv */
`timescale 1ns/1ps
`include "rfpkd_params.svh"
module rfpkd_regs #(
	parameter int SIL_UNIT_CYC = `RFPKD_SIL_UNIT_NS / `RFPKD_CLK_NS,
	parameter int PWM_STEP_CYC = `RFPKD_PWM_STEP_NS / `RFPKD_CLK_NS,
	parameter int HOLD_UNIT_CYC = `RFPKD_HOLD_UNIT_NS / `RFPKD_CLK_NS,
	// identity values below are arbitrary
	parameter logic [15:0] FW_VERSION = 16'h1000,
	parameter logic [15:0] SERIAL_HI = 16'h0001,
	parameter logic [15:0] SERIAL_LO = 16'h0002,
	parameter logic [7:0] IN_BUF_SIZE = 8'h80
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// host command port
	input wire logic cmd_valid,
	input wire rfpkd_pkg::rfpkd_cmd_t cmd,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic rsp_err,
	// host input queue and transmit engine
	input wire logic host_byte_valid,
	input wire logic queue_empty,
	output logic tx_active,
	// rf receive and retry events
	input wire logic rx_pkt_valid,
	input wire rfpkd_pkg::rfpkd_rxpkt_t rx_pkt,
	input wire logic rx_fault_evt,
	input wire logic drop_evt,
	// shared config/pwm pin
	input wire logic cfg_pin_in,
	output logic cfg_pin_out,
	output logic cfg_pin_oe,
	output logic cmd_mode,
	// input2 line decode
	output logic bin_cmd_en,
	output logic rts_flow_en
);
	localparam int SW = $clog2(SIL_UNIT_CYC + 1);
	localparam int PW = $clog2(PWM_STEP_CYC + 1);
	localparam int HW = $clog2(HOLD_UNIT_CYC + 1);

	// ************************************************
	// parameter registers and command decode
	// ************************************************
	logic [15:0] max_packet_size_reg;
	logic [15:0] packet_char_threshold_reg;
	logic [15:0] packet_silence_timeout_reg;
	logic [7:0] input2_line_function_reg;
	logic [7:0] signal_strength_pwm_hold_reg;
	logic [15:0] rx_fault_tally_reg;
	logic [15:0] rx_good_tally_reg;
	logic [15:0] unacked_drop_tally_reg;
	logic [7:0] last_signal_level_reg;
	logic wr;
	logic factory;
	logic [15:0] rd_data;
	logic rd_err;

	assign wr = cmd_valid && cmd.write;
	assign factory = cmd_valid && cmd.code == `RFPKD_CODE_FACTORY;

	always_ff @(posedge mclk) begin
		if (reset || factory) begin
			max_packet_size_reg <= `RFPKD_MAXPKT_RST;
			packet_char_threshold_reg <= `RFPKD_THRESH_RST;
			packet_silence_timeout_reg <= 16'h0000;
			input2_line_function_reg <= 8'h00;
			signal_strength_pwm_hold_reg <= 8'h00;
		end else if (wr) begin
			if (cmd.code == `RFPKD_CODE_MAXPKT) begin
				// out-of-range sizes are ignored, not clamped
				if (cmd.data >= `RFPKD_MAXPKT_MIN && cmd.data <= `RFPKD_MAXPKT_MAX) begin
					max_packet_size_reg <= cmd.data;
					if (cmd.data < packet_char_threshold_reg) begin
						packet_char_threshold_reg <= cmd.data;
					end
				end
			end else if (cmd.code == `RFPKD_CODE_THRESH) begin
				if (cmd.data != 16'h0000 && cmd.data <= max_packet_size_reg) begin
					packet_char_threshold_reg <= cmd.data;
				end
			end else if (cmd.code == `RFPKD_CODE_SILENCE) begin
				packet_silence_timeout_reg <= cmd.data;
			end else if (cmd.code == `RFPKD_CODE_IN2) begin
				if (cmd.data[7:0] <= `RFPKD_IN2_MAX && cmd.data[15:8] == 8'h00) begin
					input2_line_function_reg <= cmd.data[7:0];
				end
			end else if (cmd.code == `RFPKD_CODE_HOLD) begin
				signal_strength_pwm_hold_reg <= cmd.data[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			bin_cmd_en <= 1'b0;
			rts_flow_en <= 1'b0;
		end else begin
			bin_cmd_en <= input2_line_function_reg == `RFPKD_IN2_BINCMD;
			rts_flow_en <= input2_line_function_reg == `RFPKD_IN2_RTS;
		end
	end

	// ************************************************
	// diagnostic tallies
	// ************************************************
	// a host load in the same cycle as an event wins: the host asked for that value
	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_fault_tally_reg <= 16'h0000;
		end else if (wr && cmd.code == `RFPKD_CODE_FAULT) begin
			rx_fault_tally_reg <= cmd.data;
		end else if (rx_fault_evt && rx_fault_tally_reg != `RFPKD_TALLY_MAX) begin
			rx_fault_tally_reg <= rx_fault_tally_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_good_tally_reg <= 16'h0000;
		end else if (wr && cmd.code == `RFPKD_CODE_GOOD) begin
			rx_good_tally_reg <= cmd.data;
		end else if (rx_pkt_valid && rx_good_tally_reg != `RFPKD_TALLY_MAX) begin
			rx_good_tally_reg <= rx_good_tally_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			unacked_drop_tally_reg <= 16'h0000;
		end else if (drop_evt && unacked_drop_tally_reg != `RFPKD_TALLY_MAX) begin
			unacked_drop_tally_reg <= unacked_drop_tally_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			last_signal_level_reg <= 8'h00;
		end else if (rx_pkt_valid) begin
			last_signal_level_reg <= rx_pkt.level;
		end
	end

	// ************************************************
	// read answer
	// ************************************************
	always_comb begin
		rd_data = 16'h0000;
		rd_err = 1'b0;
		if (cmd.code == `RFPKD_CODE_MAXPKT) begin
			rd_data = max_packet_size_reg;
		end else if (cmd.code == `RFPKD_CODE_THRESH) begin
			rd_data = packet_char_threshold_reg;
		end else if (cmd.code == `RFPKD_CODE_SILENCE) begin
			rd_data = packet_silence_timeout_reg;
		end else if (cmd.code == `RFPKD_CODE_IN2) begin
			rd_data = {8'h00, input2_line_function_reg};
		end else if (cmd.code == `RFPKD_CODE_HOLD) begin
			rd_data = {8'h00, signal_strength_pwm_hold_reg};
		end else if (cmd.code == `RFPKD_CODE_FAULT) begin
			rd_data = rx_fault_tally_reg;
		end else if (cmd.code == `RFPKD_CODE_GOOD) begin
			rd_data = rx_good_tally_reg;
		end else if (cmd.code == `RFPKD_CODE_DROP) begin
			rd_data = unacked_drop_tally_reg;
		end else if (cmd.code == `RFPKD_CODE_LEVEL) begin
			rd_data = {8'h00, last_signal_level_reg};
		end else if (cmd.code == `RFPKD_CODE_FWVER) begin
			rd_data = FW_VERSION;
		end else if (cmd.code == `RFPKD_CODE_SER_HI) begin
			rd_data = SERIAL_HI;
		end else if (cmd.code == `RFPKD_CODE_SER_LO) begin
			rd_data = SERIAL_LO;
		end else if (cmd.code == `RFPKD_CODE_BUFSZ) begin
			rd_data = {8'h00, IN_BUF_SIZE};
		end else if (cmd.code == `RFPKD_CODE_FACTORY) begin
			rd_data = 16'h0000;
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_err <= 1'b0;
		end else begin
			rsp_valid <= cmd_valid;
			rsp_data <= cmd_valid ? rd_data : 16'h0000;
			rsp_err <= cmd_valid && rd_err;
		end
	end

	// ************************************************
	// packetizer
	// ************************************************
	rfpkd_pkg::rfpkd_pk_state_t pk_state;
	logic [15:0] byte_cnt;
	logic [SW-1:0] sil_pre;
	logic [15:0] sil_units;
	logic start_now;

	// silence counting is free-running per unit; any byte restarts it
	always_ff @(posedge mclk) begin
		if (reset || host_byte_valid) begin
			sil_pre <= '0;
			sil_units <= 16'h0000;
		end else if (sil_pre == SW'(SIL_UNIT_CYC - 1)) begin
			sil_pre <= '0;
			if (sil_units != 16'hFFFF) begin
				sil_units <= sil_units + 16'h0001;
			end
		end else begin
			sil_pre <= sil_pre + 1'b1;
		end
	end

	assign start_now = !queue_empty && byte_cnt != 16'h0000 &&
		(byte_cnt >= packet_char_threshold_reg ||
		(packet_silence_timeout_reg != 16'h0000 && sil_units >= packet_silence_timeout_reg));

	always_ff @(posedge mclk) begin
		if (reset) begin
			pk_state <= rfpkd_pkg::RFPKD_GATHER;
			byte_cnt <= 16'h0000;
			tx_active <= 1'b0;
		end else begin
			case (pk_state)
				rfpkd_pkg::RFPKD_GATHER: begin
					if (start_now) begin
						pk_state <= rfpkd_pkg::RFPKD_STREAM;
						tx_active <= 1'b1;
					end else if (host_byte_valid && byte_cnt != 16'hFFFF) begin
						byte_cnt <= byte_cnt + 16'h0001;
					end
				end
				default: begin
					// criteria are not rechecked while the queue still holds data
					byte_cnt <= 16'h0000;
					if (queue_empty) begin
						pk_state <= rfpkd_pkg::RFPKD_GATHER;
						tx_active <= 1'b0;
					end
				end
			endcase
		end
	end

	// ************************************************
	// signal-strength pwm and shared pin
	// ************************************************
	rfpkd_pkg::rfpkd_pin_state_t pin_state;
	logic [2:0] pin_sync;
	logic [1:0] settle_cnt;
	logic [PW-1:0] step_pre;
	logic [5:0] phase;
	logic [5:0] duty_reg;
	logic [5:0] duty_next;
	logic [8:0] margin_x3;
	logic [HW-1:0] hold_pre;
	logic [7:0] hold_left;
	logic pwm_live;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_sync <= 3'h0;
		end else begin
			pin_sync <= {pin_sync[1:0], cfg_pin_in};
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			step_pre <= '0;
			phase <= 6'h00;
		end else if (step_pre == PW'(PWM_STEP_CYC - 1)) begin
			step_pre <= '0;
			phase <= (phase == `RFPKD_PWM_STEPS - 6'h01) ? 6'h00 : phase + 6'h01;
		end else begin
			step_pre <= step_pre + 1'b1;
		end
	end

	// 0.6 step per dB above a base of 13 steps, capped at 38 of 40
	assign margin_x3 = {1'b0, rx_pkt.margin_db} * 9'h003;
	always_comb begin
		duty_next = 6'h00;
		if (rx_pkt.margin_db != 8'h00) begin
			if (rx_pkt.margin_db >= `RFPKD_MARGIN_CAP) begin
				duty_next = `RFPKD_PWM_MAX_DUTY;
			end else begin
				duty_next = `RFPKD_PWM_BASE + 6'(margin_x3 / 9'h005);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			duty_reg <= 6'h00;
		end else if (rx_pkt_valid) begin
			duty_reg <= duty_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			hold_pre <= '0;
			hold_left <= 8'h00;
		end else if (rx_pkt_valid) begin
			hold_pre <= '0;
			hold_left <= signal_strength_pwm_hold_reg;
		end else if (hold_left != 8'h00) begin
			if (hold_pre == HW'(HOLD_UNIT_CYC - 1)) begin
				hold_pre <= '0;
				hold_left <= hold_left - 8'h01;
			end else begin
				hold_pre <= hold_pre + 1'b1;
			end
		end
	end

	assign pwm_live = signal_strength_pwm_hold_reg == `RFPKD_HOLD_FOREVER || hold_left != 8'h00;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_state <= rfpkd_pkg::RFPKD_PIN_SETTLE;
			settle_cnt <= 2'h0;
			cmd_mode <= 1'b0;
			cfg_pin_oe <= 1'b0;
			cfg_pin_out <= 1'b0;
		end else begin
			case (pin_state)
				rfpkd_pkg::RFPKD_PIN_SETTLE: begin
					// wait for the synchroniser to fill before trusting the strap
					if (settle_cnt != `RFPKD_STRAP_SETTLE) begin
						settle_cnt <= settle_cnt + 2'h1;
					end else if (pin_sync[1] == pin_sync[2]) begin
						cmd_mode <= pin_sync[2];
						cfg_pin_oe <= 1'b1;
						pin_state <= rfpkd_pkg::RFPKD_PIN_LOW;
					end
				end
				rfpkd_pkg::RFPKD_PIN_LOW: begin
					cfg_pin_out <= 1'b0;
					if (rx_pkt_valid) begin
						pin_state <= rfpkd_pkg::RFPKD_PIN_PWM;
					end
				end
				default: begin
					cfg_pin_out <= pwm_live && phase < duty_reg;
				end
			endcase
		end
	end

	// ************************************************
	// checks
	// ************************************************
	a_maxpkt_range: assert property (@(posedge mclk) disable iff (reset)
		max_packet_size_reg >= `RFPKD_MAXPKT_MIN && max_packet_size_reg <= `RFPKD_MAXPKT_MAX)
		else $error("max packet size out of range");
	a_thresh_bound: assert property (@(posedge mclk) disable iff (reset)
		packet_char_threshold_reg != 16'h0000 && packet_char_threshold_reg <= max_packet_size_reg)
		else $error("threshold above packet size");
	a_thresh_start: assert property (@(posedge mclk) disable iff (reset)
		(pk_state == rfpkd_pkg::RFPKD_GATHER && !queue_empty && byte_cnt != 16'h0000 &&
		byte_cnt >= packet_char_threshold_reg) |=> tx_active)
		else $error("threshold reached without start");
	a_no_silence: assert property (@(posedge mclk) disable iff (reset)
		($rose(tx_active) && $past(packet_silence_timeout_reg) == 16'h0000) |->
		$past(byte_cnt) >= $past(packet_char_threshold_reg))
		else $error("silence start with timeout off");
	a_stream_hold: assert property (@(posedge mclk) disable iff (reset)
		(tx_active && !queue_empty) |=> tx_active)
		else $error("stream dropped with data queued");
	a_stream_end: assert property (@(posedge mclk) disable iff (reset)
		(tx_active && queue_empty) |=> !tx_active)
		else $error("stream kept on empty queue");
	a_fault_sat: assert property (@(posedge mclk) disable iff (reset)
		(rx_fault_tally_reg == `RFPKD_TALLY_MAX && !(wr && cmd.code == `RFPKD_CODE_FAULT)) |=>
		rx_fault_tally_reg == `RFPKD_TALLY_MAX)
		else $error("fault tally wrapped");
	a_good_load: assert property (@(posedge mclk) disable iff (reset)
		(wr && cmd.code == `RFPKD_CODE_GOOD) |=> rx_good_tally_reg == $past(cmd.data))
		else $error("good tally load lost");
	a_factory_rst: assert property (@(posedge mclk) disable iff (reset)
		factory |=> max_packet_size_reg == `RFPKD_MAXPKT_RST && packet_silence_timeout_reg == 16'h0000)
		else $error("factory defaults not restored");
	a_drop_count: assert property (@(posedge mclk) disable iff (reset)
		(drop_evt && unacked_drop_tally_reg != `RFPKD_TALLY_MAX) |=>
		unacked_drop_tally_reg == $past(unacked_drop_tally_reg) + 16'h0001)
		else $error("drop tally missed event");
	a_pin_low: assert property (@(posedge mclk) disable iff (reset)
		pin_state != rfpkd_pkg::RFPKD_PIN_PWM |-> !cfg_pin_out)
		else $error("shared pin high before first packet");
	a_duty_cap: assert property (@(posedge mclk) disable iff (reset)
		duty_reg <= `RFPKD_PWM_MAX_DUTY && phase < `RFPKD_PWM_STEPS)
		else $error("pwm duty or phase out of range");
	a_pwm_idle: assert property (@(posedge mclk) disable iff (reset)
		(signal_strength_pwm_hold_reg == 8'h00 && !rx_pkt_valid) |=> !cfg_pin_out)
		else $error("pwm active with hold disabled");
	a_cmd_answer: assert property (@(posedge mclk) disable iff (reset)
		cmd_valid |=> rsp_valid)
		else $error("command left unanswered");
endmodule : rfpkd_regs

/* File: verif/rfpkd_host.sv */
`timescale 1ns/1ps
module rfpkd_host (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// command port
	output rfpkd_pkg::rfpkd_cmd_t cmd,
	output logic cmd_valid,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic rsp_err,
	// serial bytes and input queue
	output logic host_byte_valid,
	output logic queue_empty,
	input wire logic tx_active
);
	logic [8:0] q_reg;
	logic [15:0] rd;
	logic er;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		host_byte_valid = 1'b0;
	end
	// queue drains one byte a cycle while the engine streams
	always_ff @(posedge mclk) begin
		if (reset)
			q_reg <= 9'h000;
		else
			q_reg <= q_reg + host_byte_valid - (tx_active && q_reg != 9'h000);
	end
	assign queue_empty = (q_reg == 9'h000);
	task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
		int n;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= {w, c, d};
		@(posedge mclk);
		cmd_valid <= 1'b0;
		// released fields show garbage, not the last command
		cmd <= ~{w, c, d};
		for (n = 0; n < 3 && rsp_valid !== 1'b1; n++)
			@(posedge mclk);
		rd = (n < 3) ? rsp_data : 16'hxxxx;
		er = (n < 3) ? rsp_err : 1'bx;
	endtask : op
	task automatic byte_in();
		@(posedge mclk);
		host_byte_valid <= 1'b1;
		@(posedge mclk);
		host_byte_valid <= 1'b0;
	endtask : byte_in
endmodule : rfpkd_host

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic cmd_valid, rsp_valid, rsp_err, host_byte_valid, queue_empty, tx_active;
	logic [15:0] rsp_data;
	rfpkd_pkg::rfpkd_cmd_t cmd;
	logic rx_pkt_valid = 1'b0;
	logic rx_fault_evt = 1'b0;
	logic drop_evt = 1'b0;
	rfpkd_pkg::rfpkd_rxpkt_t rx_pkt = '0;
	logic cfg_pin_out, cfg_pin_oe, cmd_mode, bin_cmd_en, rts_flow_en, cfg_pin_in;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int hi_n, rise_n;
	// strap pulled high while the pin is still an input
	assign cfg_pin_in = cfg_pin_oe ? cfg_pin_out : 1'b1;
	always #5 mclk = ~mclk;
	rfpkd_regs #(.SIL_UNIT_CYC(4), .PWM_STEP_CYC(2), .HOLD_UNIT_CYC(8),
		.FW_VERSION(16'h1000), .SERIAL_HI(16'h0001), .SERIAL_LO(16'h0002), .IN_BUF_SIZE(8'h80)) u_dut (
		.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.host_byte_valid(host_byte_valid), .queue_empty(queue_empty), .tx_active(tx_active),
		.rx_pkt_valid(rx_pkt_valid), .rx_pkt(rx_pkt), .rx_fault_evt(rx_fault_evt), .drop_evt(drop_evt),
		.cfg_pin_in(cfg_pin_in), .cfg_pin_out(cfg_pin_out), .cfg_pin_oe(cfg_pin_oe),
		.cmd_mode(cmd_mode), .bin_cmd_en(bin_cmd_en), .rts_flow_en(rts_flow_en));
	rfpkd_host u_host (
		.mclk(mclk), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.host_byte_valid(host_byte_valid), .queue_empty(queue_empty), .tx_active(tx_active));
	// ************
	// helpers
	// ************
	task automatic tally_and_finish();
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] c, input logic [15:0] exp);
		u_host.op(1'b0, c, 16'h0000);
		chk(u_host.rd, exp);
	endtask : rc
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		u_host.op(1'b1, c, d);
	endtask : wr
	task automatic wait_tx(input logic v, input int lim);
		for (int i = 0; i < lim && tx_active !== v; i++)
			@(posedge mclk);
		chk({15'h0000, tx_active}, {15'h0000, v});
	endtask : wait_tx
	task automatic pkt(input logic [7:0] m);
		@(posedge mclk);
		rx_pkt_valid <= 1'b1;
		rx_pkt <= {m + 8'h06, m};
		@(posedge mclk);
		rx_pkt_valid <= 1'b0;
	endtask : pkt
	// two full pwm periods: high cycles and rising edges
	task automatic meas();
		logic p;
		hi_n = 0;
		rise_n = 0;
		// seed from the live level so a window that opens with the pin already high does not count a rise there
		#1;
		p = cfg_pin_out;
		for (int i = 0; i < 160; i++) begin
			@(posedge mclk);
			#1;
			hi_n += int'(cfg_pin_out === 1'b1);
			rise_n += int'(cfg_pin_out === 1'b1 && !p);
			p = cfg_pin_out;
		end
	endtask : meas
	// ************
	// scenarios
	// ************
	task automatic t_regs();
		rc(8'h29, 16'h0040);
		rc(8'h20, 16'h0001);
		rc(8'h21, 16'h0000);
		rc(8'h16, 16'h0000);
		rc(8'h0F, 16'h0000);
		rc(8'h10, 16'h0000);
		rc(8'h1B, 16'h0000);
		rc(8'h2C, 16'h0080);
		rc(8'h25, 16'h0001);
		rc(8'h26, 16'h0002);
		wr(8'h14, 16'h5555);
		rc(8'h14, 16'h1000);
		wr(8'h2C, 16'h0011);
		rc(8'h2C, 16'h0080);
		rc(8'h30, 16'h0000);
		chk({15'h0000, u_host.er}, 16'h0001);
		chk({14'h0000, cfg_pin_oe, cfg_pin_out}, 16'h0002);
		chk({15'h0000, cmd_mode}, 16'h0001);
	endtask : t_regs
	task automatic t_size();
		wr(8'h21, 16'h0005);
		wr(8'h20, 16'h0030);
		wr(8'h29, 16'h0010);
		rc(8'h20, 16'h0010);
		wr(8'h29, 16'h0001);
		wr(8'h29, 16'h0101);
		rc(8'h29, 16'h0010);
		wr(8'h20, 16'h0000);
		wr(8'h20, 16'h0011);
		rc(8'h20, 16'h0010);
		wr(8'h29, 16'h0100);
		wr(8'h20, 16'h0100);
		rc(8'h20, 16'h0100);
		wr(8'h29, 16'h0002);
		rc(8'h20, 16'h0002);
		wr(8'h0E, 16'h0000);
		rc(8'h29, 16'h0040);
		rc(8'h20, 16'h0001);
		rc(8'h21, 16'h0000);
	endtask : t_size
	task automatic t_in2();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 8'(i);
			wr(8'h16, {8'h00, v});
			@(posedge mclk);
			#1;
			// code 3 is refused, so decode stays at 2
			chk({14'h0000, rts_flow_en, bin_cmd_en}, (i == 3) ? 16'h0002 : 16'(i));
		end
		wr(8'h16, 16'h0000);
	endtask : t_in2
	task automatic t_tally();
		wr(8'h0F, 16'hFFFE);
		repeat (2) begin
			@(posedge mclk) rx_fault_evt <= 1'b1;
			@(posedge mclk) rx_fault_evt <= 1'b0;
			@(posedge mclk) drop_evt <= 1'b1;
			@(posedge mclk) drop_evt <= 1'b0;
		end
		rc(8'h0F, 16'hFFFF);
		wr(8'h0F, 16'h0003);
		rc(8'h0F, 16'h0003);
		wr(8'h10, 16'hFFFF);
		pkt(8'h00);
		rc(8'h10, 16'hFFFF);
		wr(8'h10, 16'h0005);
		pkt(8'h00);
		rc(8'h10, 16'h0006);
		rc(8'h1B, 16'h0002);
		wr(8'h1B, 16'h0007);
		rc(8'h1B, 16'h0002);
	endtask : t_tally
	task automatic t_thresh();
		wr(8'h20, 16'h0003);
		repeat (2) u_host.byte_in();
		repeat (50) @(posedge mclk);
		chk({15'h0000, tx_active}, 16'h0000);
		u_host.byte_in();
		wait_tx(1'b1, 5);
		wait_tx(1'b0, 10);
		chk({15'h0000, queue_empty}, 16'h0001);
	endtask : t_thresh
	task automatic t_silence();
		wr(8'h20, 16'h0010);
		wr(8'h21, 16'h0002);
		u_host.byte_in();
		repeat (3) begin
			repeat (3) @(posedge mclk);
			u_host.byte_in();
		end
		// two units of four cycles: still idle seven cycles after the last byte
		repeat (7) @(posedge mclk);
		chk({15'h0000, tx_active}, 16'h0000);
		wait_tx(1'b1, 5);
		wait_tx(1'b0, 20);
		wr(8'h21, 16'h0000);
	endtask : t_silence
	task automatic t_pwm();
		logic [7:0] m [3] = '{8'h0A, 8'h1E, 8'h00};
		logic [15:0] e [3] = '{16'h004C, 16'h007C, 16'h0000};
		wr(8'h22, 16'h00FF);
		for (int i = 0; i < 3; i++) begin
			pkt(m[i]);
			repeat (80) @(posedge mclk);
			meas();
			chk(16'(hi_n), e[i]);
			chk(16'(rise_n), (i == 2) ? 16'h0000 : 16'h0002);
		end
		rc(8'h1C, 16'h0006);
		// forty hold units outlast the measuring window, then the pin must fall
		wr(8'h22, 16'h0028);
		pkt(8'h14);
		meas();
		chk(16'(hi_n), 16'h0064);
		repeat (170) @(posedge mclk);
		meas();
		chk(16'(hi_n), 16'h0000);
	endtask : t_pwm
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		repeat (10) @(posedge mclk);
		t_regs();
		t_size();
		t_in2();
		t_tally();
		t_thresh();
		t_silence();
		t_pwm();
		tally_and_finish();
	end
endmodule : testbench
